/* hw/sdats_top.sv */
// SD/MMC auto transfer sequencer: DMA command handling, card command flow
//
// Our own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
module sdats_top #(
  parameter int unsigned HOLD_CYCLES = sdats_pkg::HOLD_CYCLES
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // DMA command interface
  input  wire logic        cmd_valid,
  output logic             cmd_ack,
  input  wire logic [31:0] start_addr,
  input  wire logic [31:0] xfer_len,
  input  wire logic [2:0]  block_size,
  input  wire logic [2:0]  cmd_op,
  input  wire logic        dev_sel,
  input  wire logic [3:0]  dev_id,
  output logic             fmc_err,
  // DMA data movement
  output logic             dma_ready,
  input  wire logic        byte_strobe,
  input  wire logic        dma_done,
  // Card link
  input  wire logic        card_clk,
  output logic             card_clk_en,
  input  wire logic        cmd_in,
  output logic             cmd_out,
  output logic             cmd_oe_n
);
  // Hold limit in clock cycles, cut to the counter width on purpose
  localparam logic [16:0] HOLD_LIM = 17'(HOLD_CYCLES - 1);

  // Bus side registers
  logic [31:0]             ctrl, next_ctrl;
  logic [15:0]             rca, next_rca;
  logic                    wr_pend, next_wr_pend;
  logic [7:0]              wr_addr, next_wr_addr;
  logic [31:0]             next_hrdata;
  logic                    ap_valid;
  // Sequencer state
  sdats_pkg::sdats_state_e state, next_state;
  logic [2:0]              op_q, next_op_q;
  logic [31:0]             maddr, next_maddr;
  logic [31:0]             len_cnt, next_len_cnt;
  logic [31:0]             req_len, next_req_len;
  logic                    pend, next_pend;
  logic                    txn_rd, next_txn_rd;
  logic                    issued, next_issued;
  logic [16:0]             hold_cnt, next_hold_cnt;
  logic [7:0]              info, next_info;
  logic                    next_fmc_err;
  logic                    next_clk_en;
  // Decoded conditions
  logic                    lba;
  logic                    stream_cont;
  logic                    cont_match;
  logic                    cmd_take;
  logic                    man_op;
  logic                    cmd_phase;

  // Command engine link
  sdats_cmd_if cmd_bus ();

  // All checks run on the bus clock
  default clocking seq_cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // True for both write commands and the manual write
  function automatic logic op_wr(input logic [2:0] op);
    return (op == sdats_pkg::OP_NEW_WR) || (op == sdats_pkg::OP_CONTINUOUS_WRITE_HOLD) ||
           (op == sdats_pkg::OP_MAN_WR);
  endfunction : op_wr

  // Manual commands skip card commands; firmware has prepared the card
  function automatic logic op_man(input logic [2:0] op);
    return (op == sdats_pkg::OP_MAN_RD) || (op == sdats_pkg::OP_MAN_WR);
  endfunction : op_man

  // Blocks of 512 bytes to bytes; upper bits fall off the 32-bit word
  function automatic logic [31:0] blk_bytes(input logic [31:0] n);
    return {n[22:0], 9'h000};
  endfunction : blk_bytes

  // First state of a fresh transfer
  function automatic sdats_pkg::sdats_state_e first_state(input logic [2:0] op);
    if (op_man(op)) begin
      return sdats_pkg::S_KICK;
    end else if (op_wr(op)) begin
      return sdats_pkg::S_APP;
    end else begin
      return sdats_pkg::S_MULTI;
    end
  endfunction : first_state

  // Zero-wait slave: a word transfer is taken in its address phase
  assign ap_valid  = hsel & htrans[1] & hready & (hsize == sdats_pkg::HSIZE_WORD);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Addressing mode from the device option field or the large-media flag
  assign lba         = ctrl[sdats_pkg::CTRL_LARGE] |
                       (ctrl[sdats_pkg::CTRL_DEVOPT +: 3] == sdats_pkg::LBA_DEVOPT);
  assign stream_cont = ctrl[sdats_pkg::CTRL_STREAM] & ctrl[sdats_pkg::CTRL_EP_CONT];
  assign cont_match  = txn_rd ? (cmd_op == sdats_pkg::OP_CONTINUOUS_READ_HOLD) :
                                (cmd_op == sdats_pkg::OP_CONTINUOUS_WRITE_HOLD);
  assign man_op      = op_man(cmd_op);
  // Commands wait while a card command or a counted block is under way
  assign cmd_take    = cmd_valid & ((state == sdats_pkg::S_IDLE) |
                                    (state == sdats_pkg::S_HOLD) |
                                    ((state == sdats_pkg::S_XFER) & stream_cont));
  assign cmd_ack     = cmd_take;
  assign dma_ready   = (state == sdats_pkg::S_XFER);
  assign cmd_phase   = (state == sdats_pkg::S_STOP) | (state == sdats_pkg::S_APP) |
                       (state == sdats_pkg::S_ERASE) | (state == sdats_pkg::S_MULTI);

  // One request per command state; the flag drops with the answer
  assign cmd_bus.req = cmd_phase & ~issued;
  assign cmd_bus.rsp = 1'b1;

  // Command index and argument for the current state
  always_comb begin
    cmd_bus.index = sdats_pkg::CI_STOP;
    cmd_bus.arg   = 32'h0000_0000;
    case (state)
      sdats_pkg::S_APP: begin
        cmd_bus.index = sdats_pkg::CI_APP;
        cmd_bus.arg   = {rca, 16'h0000};
      end
      sdats_pkg::S_ERASE: begin
        cmd_bus.index = sdats_pkg::CI_ERASE;
        cmd_bus.arg   = req_len;
      end
      sdats_pkg::S_MULTI: begin
        cmd_bus.index = txn_rd ? sdats_pkg::CI_RD_MULTI : sdats_pkg::CI_WR_MULTI;
        cmd_bus.arg   = maddr;
      end
      default: begin
        cmd_bus.arg = 32'h0000_0000;
      end
    endcase
  end

  // Register writes land in the data phase; reads are latched in the address phase
  always_comb begin
    next_ctrl    = ctrl;
    next_rca     = rca;
    next_wr_pend = ap_valid & hwrite;
    next_wr_addr = ap_valid ? haddr[7:0] : wr_addr;
    next_hrdata  = hrdata;
    if (wr_pend) begin
      if (wr_addr == sdats_pkg::A_CTRL) begin
        next_ctrl = hwdata;
      end else if (wr_addr == sdats_pkg::A_RCA) begin
        next_rca = hwdata[15:0];
      end
    end
    if (ap_valid && !hwrite) begin
      if (haddr[7:0] == sdats_pkg::A_CTRL) begin
        next_hrdata = ctrl;
      end else if (haddr[7:0] == sdats_pkg::A_RCA) begin
        next_hrdata = {16'h0000, rca};
      end else if (haddr[7:0] == sdats_pkg::A_STATUS) begin
        next_hrdata = {19'h0_0000, info, fmc_err, state};
      end else if (haddr[7:0] == sdats_pkg::A_LEN) begin
        next_hrdata = len_cnt;
      end else if (haddr[7:0] == sdats_pkg::A_ADDR) begin
        next_hrdata = maddr;
      end else begin
        next_hrdata = 32'h0000_0000;
      end
    end
  end

  // Bus side registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl    <= sdats_pkg::RST_CTRL;
      rca     <= sdats_pkg::RST_RCA;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata  <= 32'h0000_0000;
    end else begin
      ctrl    <= next_ctrl;
      rca     <= next_rca;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata  <= next_hrdata;
    end
  end

  // Sequencer: command flow, byte counting and the idle hold timer
  always_comb begin
    next_state    = state;
    next_op_q     = op_q;
    next_maddr    = maddr;
    next_len_cnt  = len_cnt;
    next_req_len  = req_len;
    next_pend     = pend;
    next_txn_rd   = txn_rd;
    next_fmc_err  = fmc_err;
    next_info     = info;
    next_issued   = issued;
    next_hold_cnt = 17'h0_0000;
    if (cmd_bus.done) begin
      next_issued = 1'b0;
    end else if (cmd_bus.req) begin
      next_issued = 1'b1;
    end
    // A taken command fixes address, length and direction at once
    if (cmd_take) begin
      next_op_q    = cmd_op;
      next_maddr   = lba ? start_addr : blk_bytes(start_addr);
      next_req_len = xfer_len;
      next_len_cnt = man_op ? xfer_len : blk_bytes(xfer_len);
      next_txn_rd  = ~op_wr(cmd_op);
      next_fmc_err = 1'b0;
      next_info    = {dev_id, dev_sel, block_size};
    end
    if (cmd_bus.done && cmd_bus.err) begin
      // A bad answer never starts the data movement
      next_state   = sdats_pkg::S_IDLE;
      next_fmc_err = 1'b1;
      next_pend    = 1'b0;
    end else begin
      case (state)
        sdats_pkg::S_IDLE: begin
          if (cmd_take) begin
            next_state = first_state(cmd_op);
          end
        end
        sdats_pkg::S_STOP: begin
          if (cmd_bus.done && pend) begin
            next_state = first_state(op_q);
            next_pend  = 1'b0;
          end else if (cmd_bus.done) begin
            next_state = sdats_pkg::S_IDLE;
          end
        end
        sdats_pkg::S_APP: begin
          if (cmd_bus.done) begin
            next_state = ctrl[sdats_pkg::CTRL_CONTINUOUS_WRITE_HOLD] ? sdats_pkg::S_MULTI :
                                                         sdats_pkg::S_ERASE;
          end
        end
        sdats_pkg::S_ERASE: begin
          if (cmd_bus.done) begin
            next_state = sdats_pkg::S_MULTI;
          end
        end
        sdats_pkg::S_MULTI: begin
          if (cmd_bus.done) begin
            next_state = sdats_pkg::S_KICK;
          end
        end
        sdats_pkg::S_KICK: begin
          next_state = sdats_pkg::S_XFER;
        end
        sdats_pkg::S_XFER: begin
          if (byte_strobe && len_cnt != 32'h0000_0000 && !cmd_take) begin
            next_len_cnt = len_cnt - 32'h0000_0001;
            if (op_q == sdats_pkg::OP_NEW_WR) begin
              next_maddr = maddr + 32'h0000_0001;
            end
          end
          // Streaming with a continuous endpoint ends only on a new command
          if (cmd_take && !cont_match) begin
            next_state = sdats_pkg::S_STOP;
            next_pend  = 1'b1;
          end else if (dma_done && !stream_cont) begin
            if (op_man(op_q)) begin
              next_state = sdats_pkg::S_IDLE;
            end else if (txn_rd ? ctrl[sdats_pkg::CTRL_CONTINUOUS_READ_HOLD] :
                                  ctrl[sdats_pkg::CTRL_CONTINUOUS_WRITE_HOLD]) begin
              next_state = sdats_pkg::S_HOLD;
            end else begin
              next_state = sdats_pkg::S_STOP;
            end
          end
        end
        sdats_pkg::S_HOLD: begin
          next_hold_cnt = hold_cnt + 17'h0_0001;
          if (cmd_take && cont_match) begin
            next_state = sdats_pkg::S_XFER;
          end else if (cmd_take) begin
            next_state = sdats_pkg::S_STOP;
            next_pend  = 1'b1;
          end else if (hold_cnt == HOLD_LIM) begin
            next_state = sdats_pkg::S_STOP;
          end
        end
        default: begin
          next_state = sdats_pkg::S_IDLE;
        end
      endcase
    end
  end

  // Card clock runs for commands and, unless streaming, until the byte count is used up
  always_comb begin
    case (next_state)
      sdats_pkg::S_STOP, sdats_pkg::S_APP, sdats_pkg::S_ERASE, sdats_pkg::S_MULTI,
      sdats_pkg::S_KICK: begin
        next_clk_en = 1'b1;
      end
      sdats_pkg::S_XFER: begin
        next_clk_en = ctrl[sdats_pkg::CTRL_STREAM] | (next_len_cnt != 32'h0000_0000);
      end
      default: begin
        next_clk_en = 1'b0;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state       <= sdats_pkg::S_IDLE;
      op_q        <= 3'h0;
      maddr       <= 32'h0000_0000;
      len_cnt     <= 32'h0000_0000;
      req_len     <= 32'h0000_0000;
      pend        <= 1'b0;
      txn_rd      <= 1'b1;
      issued      <= 1'b0;
      hold_cnt    <= 17'h0_0000;
      info        <= 8'h00;
      fmc_err     <= 1'b0;
      card_clk_en <= 1'b0;
    end else begin
      state       <= next_state;
      op_q        <= next_op_q;
      maddr       <= next_maddr;
      len_cnt     <= next_len_cnt;
      req_len     <= next_req_len;
      pend        <= next_pend;
      txn_rd      <= next_txn_rd;
      issued      <= next_issued;
      hold_cnt    <= next_hold_cnt;
      info        <= next_info;
      fmc_err     <= next_fmc_err;
      card_clk_en <= next_clk_en;
    end
  end

  // Serial command engine on the card command line
  sdats_cmd_engine eng_u (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .cmd      (cmd_bus),
    .card_clk (card_clk),
    .cmd_in   (cmd_in),
    .cmd_out  (cmd_out),
    .cmd_oe_n (cmd_oe_n)
  );

  // Sequencer checks
  fresh_start_a: assert property ((state == sdats_pkg::S_IDLE) && cmd_take &&
    (cmd_op == sdats_pkg::OP_NEW_RD) |=> (state == sdats_pkg::S_MULTI))
    else $error("idle read did not start with a read command");
  continue_skip_a: assert property ((state == sdats_pkg::S_HOLD) && cmd_take &&
    cont_match |=> (state == sdats_pkg::S_XFER))
    else $error("continuation did not go straight to data");
  stop_first_a: assert property ((state == sdats_pkg::S_HOLD) && cmd_take &&
    !cont_match |=> (state == sdats_pkg::S_STOP))
    else $error("new command did not close the open transaction");
  bad_answer_a: assert property (cmd_bus.done && cmd_bus.err |=>
    (state == sdats_pkg::S_IDLE) && fmc_err)
    else $error("error answer did not abort the transfer");
  clock_stop_a: assert property ((state == sdats_pkg::S_XFER) && !cmd_take && !dma_done &&
    (len_cnt == 32'h0000_0000) && !ctrl[sdats_pkg::CTRL_STREAM] |=> !card_clk_en)
    else $error("card clock still runs at zero count");
  hold_close_a: assert property ((state == sdats_pkg::S_HOLD) && !cmd_take &&
    (hold_cnt == HOLD_LIM) |=> (state == sdats_pkg::S_STOP))
    else $error("held transaction not closed after hold time");
  addr_step_a: assert property ((state == sdats_pkg::S_XFER) && byte_strobe && !cmd_take &&
    (op_q == sdats_pkg::OP_NEW_WR) && (len_cnt != 32'h0000_0000) |=>
    (maddr == $past(maddr) + 32'h0000_0001))
    else $error("write address did not advance per byte");
  // Main scenarios
  hold_resume_c: cover property ((state == sdats_pkg::S_HOLD) && cmd_take && cont_match);
  erase_seen_c: cover property (state == sdats_pkg::S_ERASE);
  hold_expiry_c: cover property ((state == sdats_pkg::S_HOLD) ##1 (state == sdats_pkg::S_STOP));
endmodule : sdats_top

/* hw/sdats_pkg.sv */
// Shared constants and types of the SD/MMC auto transfer sequencer
package sdats_pkg;
  // Register byte offsets
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_RCA    = 8'h04;
  localparam logic [7:0] A_STATUS = 8'h08;
  localparam logic [7:0] A_LEN    = 8'h0c;
  localparam logic [7:0] A_ADDR   = 8'h10;
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;
  localparam logic [15:0] RST_RCA  = 16'h0000;
  // Control field positions
  localparam int CTRL_CONTINUOUS_READ_HOLD = 0;
  localparam int CTRL_CONTINUOUS_WRITE_HOLD = 1;
  localparam int CTRL_LARGE   = 2;
  localparam int CTRL_STREAM  = 3;
  localparam int CTRL_EP_CONT = 4;
  localparam int CTRL_DEVOPT  = 8;
  localparam logic [2:0] LBA_DEVOPT = 3'h4;
  // Transfer commands on the DMA command interface
  localparam logic [2:0] OP_NEW_RD  = 3'h0;
  localparam logic [2:0] OP_CONTINUOUS_READ_HOLD = 3'h1;
  localparam logic [2:0] OP_NEW_WR  = 3'h2;
  localparam logic [2:0] OP_CONTINUOUS_WRITE_HOLD = 3'h3;
  localparam logic [2:0] OP_MAN_RD  = 3'h4;
  localparam logic [2:0] OP_MAN_WR  = 3'h5;
  // Card command indices
  localparam logic [5:0] CI_STOP     = 6'h0c;
  localparam logic [5:0] CI_APP      = 6'h37;
  localparam logic [5:0] CI_ERASE    = 6'h17;
  localparam logic [5:0] CI_RD_MULTI = 6'h12;
  localparam logic [5:0] CI_WR_MULTI = 6'h19;
  localparam logic [31:0] RSP_ERR_MASK = 32'hfff8_0000;
  // Link framing and timing counts
  localparam logic [7:0] FRAME_BITS  = 8'h30;
  localparam logic [7:0] RSP_TIMEOUT = 8'h40;
  localparam logic [4:0] TAIL_BITS   = 5'h11;
  localparam int HOLD_TIME_US  = 1000;
  localparam int CLK_PERIOD_PS = 8000;
  localparam int HOLD_CYCLES   = HOLD_TIME_US * 1000000 / CLK_PERIOD_PS;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  // Sequencer states
  typedef enum logic [3:0] {
    S_IDLE, S_STOP, S_APP, S_ERASE, S_MULTI, S_KICK, S_XFER, S_HOLD
  } sdats_state_e;
endpackage : sdats_pkg

/* hw/sdats_cmd_if.sv */
// Card command request and answer between sequencer and command engine
`timescale 1ns/1ps
interface sdats_cmd_if;
  logic        req;
  logic [5:0]  index;
  logic [31:0] arg;
  logic        rsp;
  logic        done;
  logic        err;
  logic        rise;
  modport seq (output req, index, arg, rsp, input done, err, rise);
  modport eng (input req, index, arg, rsp, output done, err, rise);
endinterface : sdats_cmd_if

/* hw/sdats_cmd_engine.sv */
// Serial card command engine: frames commands and collects responses
`timescale 1ns/1ps
module sdats_cmd_engine (
  // Clock and reset
  input  wire logic   hclk,
  input  wire logic   hresetn,
  // Sequencer side
  sdats_cmd_if.eng    cmd,
  // Card command line
  input  wire logic   card_clk,
  input  wire logic   cmd_in,
  output logic        cmd_out,
  output logic        cmd_oe_n
);
  typedef enum logic [1:0] {E_IDLE, E_SEND, E_WAIT, E_RECV} sdats_eng_e;

  sdats_eng_e  state, next_state;
  logic [47:0] sh, next_sh;
  logic [7:0]  cnt, next_cnt;
  logic        next_out, next_oe_n, next_done, next_err;
  logic        clk_s1, clk_s2, clk_s3, cin_s1, cin_s2;
  logic        fall;
  logic [47:0] frame;

  function automatic logic [6:0] crc7(input logic [39:0] d);
    logic [6:0] c;
    logic       fb;
    c = 7'h00;
    for (int i = 39; i >= 0; i--) begin
      fb = d[i] ^ c[6];
      c  = {c[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
    end
    return c;
  endfunction : crc7

  // Edges found from the second and third stages, the first feeds nothing else
  assign cmd.rise = clk_s2 & ~clk_s3;
  assign fall     = ~clk_s2 & clk_s3;
  assign frame    = {sh[46:0], cin_s2};

  // Drive on falling edges so the card samples stable bits on rising ones
  always_comb begin
    next_state = state;
    next_sh    = sh;
    next_cnt   = cnt;
    next_out   = cmd_out;
    next_oe_n  = cmd_oe_n;
    next_done  = 1'b0;
    next_err   = 1'b0;
    case (state)
      E_IDLE: if (cmd.req) begin
        next_sh    = {2'b01, cmd.index, cmd.arg, crc7({2'b01, cmd.index, cmd.arg}), 1'b1};
        next_cnt   = 8'h00;
        next_state = E_SEND;
      end
      E_SEND: if (fall) begin
        if (cnt == sdats_pkg::FRAME_BITS) begin
          next_oe_n  = 1'b1;
          next_out   = 1'b1;
          next_cnt   = 8'h00;
          next_state = cmd.rsp ? E_WAIT : E_IDLE;
          next_done  = ~cmd.rsp;
        end else begin
          next_oe_n = 1'b0;
          next_out  = sh[47];
          next_sh   = {sh[46:0], 1'b0};
          next_cnt  = cnt + 8'h01;
        end
      end
      E_WAIT: if (cmd.rise) begin
        next_cnt = cnt + 8'h01;
        if (!cin_s2) begin
          next_sh    = 48'h0000_0000_0000;
          next_cnt   = 8'h01;
          next_state = E_RECV;
        end else if (cnt == sdats_pkg::RSP_TIMEOUT) begin
          next_done  = 1'b1;
          next_err   = 1'b1;
          next_state = E_IDLE;
        end
      end
      E_RECV: if (cmd.rise) begin
        next_sh  = frame;
        next_cnt = cnt + 8'h01;
        if (cnt == sdats_pkg::FRAME_BITS - 8'h01) begin
          // Missing end bit or any error bit fails the command
          next_done  = 1'b1;
          next_err   = ~frame[0] | (|(frame[39:8] & sdats_pkg::RSP_ERR_MASK));
          next_state = E_IDLE;
        end
      end
      default: next_state = E_IDLE;
    endcase
  end

  // Registers and synchronisers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state    <= E_IDLE;
      sh       <= 48'h0000_0000_0000;
      cnt      <= 8'h00;
      cmd_out  <= 1'b1;
      cmd_oe_n <= 1'b1;
      cmd.done <= 1'b0;
      cmd.err  <= 1'b0;
      clk_s1   <= 1'b0;
      clk_s2   <= 1'b0;
      clk_s3   <= 1'b0;
      cin_s1   <= 1'b1;
      cin_s2   <= 1'b1;
    end else begin
      state    <= next_state;
      sh       <= next_sh;
      cnt      <= next_cnt;
      cmd_out  <= next_out;
      cmd_oe_n <= next_oe_n;
      cmd.done <= next_done;
      cmd.err  <= next_err;
      clk_s1   <= card_clk;
      clk_s2   <= clk_s1;
      clk_s3   <= clk_s2;
      cin_s1   <= cmd_in;
      cin_s2   <= cin_s1;
    end
  end
endmodule : sdats_cmd_engine

/* sim/sdats_card.sv */
// Card model: takes command frames, answers
`timescale 1ns/1ps
module sdats_card (
  // Card link
  input  wire logic card_clk,
  input  wire logic cmd_out,
  input  wire logic cmd_oe_n,
  output logic      cmd_drv
);
  logic [47:0] sh;
  logic [47:0] tx;
  int          n = 0;
  int          k = 0;
  logic [37:0] log_q[$];
  // Frame check code
  function automatic logic [6:0] crc7(input logic [39:0] d);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 39; i >= 0; i--) c = {c[5:0], 1'b0} ^ {3'h0, d[i]^c[6], 2'h0, d[i]^c[6]};
    return c;
  endfunction : crc7
  // Capture while driven; clean status so the DMA may start
  always @(posedge card_clk) begin
    if (!cmd_oe_n && (n > 0 || !cmd_out)) begin
      sh <= {sh[46:0], cmd_out};
      n <= (n == 47) ? 0 : n + 1;
      if (n == 47) begin
        log_q.push_back({sh[44:39], sh[38:7]});
        tx <= {2'b00, sh[44:39], 32'h0, crc7({2'b00, sh[44:39], 32'h0}), 1'b1};
        k <= 50;
      end
    end
  end
  // Answer after a short turnaround, pull-up when released
  always @(negedge card_clk) begin
    if (k > 0) k <= k - 1;
    if (k > 0 && k < 49) tx <= tx << 1;
    cmd_drv <= (k > 0 && k < 49) ? tx[47] : 1'b1;
  end
endmodule : sdats_card

/* sim/test_sd_mmc_auto_transfer_sequencer.sv */
// Bench of the auto transfer sequencer
`timescale 1ns/1ps
module test_sd_mmc_auto_transfer_sequencer;
  localparam int HOLD = 300;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, card_clk = 0;
  logic [31:0] haddr = 0, hwdata = 0, start_addr = 0, xfer_len = 1, hrdata;
  logic [2:0]  hsize = 2, block_size = 0, cmd_op = 0;
  logic [1:0]  htrans = 0;
  logic [3:0]  dev_id = 0;
  logic        cmd_valid = 0, dev_sel = 0, byte_strobe = 0, dma_done = 0, cmd_drv;
  logic        hreadyout, hresp, cmd_ack, fmc_err, dma_ready, card_clk_en, cmd_out, cmd_oe_n;
  int          errors = 0, n_checks = 0, cyc = 0;
  // Wire level of the shared command line
  wire         cmd_in = cmd_oe_n ? cmd_drv : cmd_out;
  sdats_top #(.HOLD_CYCLES(HOLD)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .cmd_valid(cmd_valid), .cmd_ack(cmd_ack), .start_addr(start_addr), .xfer_len(xfer_len),
    .block_size(block_size), .cmd_op(cmd_op), .dev_sel(dev_sel), .dev_id(dev_id),
    .fmc_err(fmc_err), .dma_ready(dma_ready), .byte_strobe(byte_strobe),
    .dma_done(dma_done), .card_clk(card_clk), .card_clk_en(card_clk_en),
    .cmd_in(cmd_in), .cmd_out(cmd_out), .cmd_oe_n(cmd_oe_n));
  sdats_card card_u (.card_clk(card_clk), .cmd_out(cmd_out), .cmd_oe_n(cmd_oe_n),
    .cmd_drv(cmd_drv));
  initial forever #4 hclk = ~hclk;
  // Link clock runs only while the block enables it
  initial forever #62.5 card_clk = card_clk_en ? ~card_clk : 1'b0;
  task automatic stop_test;
    $display("errors=%0d checks=%0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  // Hang guard
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      stop_test();
    end
  end
  task automatic chk(input logic [37:0] got, input logic [37:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [37:0] ex(input logic [5:0] i, input logic [31:0] a, input logic lba);
    return {i, lba ? a : a << 9};
  endfunction : ex
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    chk(38'(hresp), 38'h0);
  endtask : ahb
  task automatic dma_command_interface(input logic [2:0] op, input logic [31:0] a);
    cmd_op <= op;
    start_addr <= a;
    cmd_valid <= 1'b1;
    @(posedge hclk);
    while (cmd_ack !== 1'b1) @(posedge hclk);
    cmd_valid <= 1'b0;
  endtask : dma_command_interface
  task automatic move;
    while (dma_ready !== 1'b1) @(posedge hclk);
    byte_strobe <= 1'b1;
    repeat (512) @(posedge hclk);
    byte_strobe <= 1'b0;
    dma_done <= 1'b1;  // Stands for the block done irq
    @(posedge hclk);
    dma_done <= 1'b0;
    @(posedge hclk);
  endtask : move
  task automatic wlog(input int n);
    while (card_u.log_q.size() < n) @(posedge hclk);
  endtask : wlog
  function automatic logic [37:0] ix(input int p);
    return 38'(card_u.log_q[p][37:32]);
  endfunction : ix
  initial begin
    logic [31:0] a;
    a = $urandom(62);
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1, 32'(sdats_pkg::A_RCA), 32'h0000_5a5a);
    ahb(0, 32'(sdats_pkg::A_RCA), 32'h0);
    chk(38'(hrdata[15:0]), 38'h5a5a);
    ahb(0, 32'h0000_0080, 32'h0);
    a = $urandom % 4096;
    dma_command_interface(sdats_pkg::OP_NEW_RD, a);
    wlog(1);
    chk(card_u.log_q[0], ex(sdats_pkg::CI_RD_MULTI, a, 0));
    move();
    wlog(2);
    chk(ix(1), 38'(sdats_pkg::CI_STOP));
    ahb(1, 32'(sdats_pkg::A_CTRL), 32'h0000_0400);
    a = $urandom;
    dma_command_interface(sdats_pkg::OP_NEW_WR, a);
    wlog(5);
    chk(ix(2), 38'(sdats_pkg::CI_APP));
    chk(ix(3), 38'(sdats_pkg::CI_ERASE));
    chk(card_u.log_q[4], ex(sdats_pkg::CI_WR_MULTI, a, 1));
    move();
    wlog(6);
    chk(ix(5), 38'(sdats_pkg::CI_STOP));
    ahb(1, 32'(sdats_pkg::A_CTRL), 32'h0000_0401);
    dma_command_interface(sdats_pkg::OP_NEW_RD, a);
    move();
    dma_command_interface(sdats_pkg::OP_CONTINUOUS_READ_HOLD, a);
    move();
    repeat (HOLD / 2) @(posedge hclk);
    chk(38'(card_u.log_q.size()), 38'd7);
    wlog(8);
    chk(ix(7), 38'(sdats_pkg::CI_STOP));
    dma_command_interface(sdats_pkg::OP_MAN_RD, a);
    move();
    chk(38'(card_u.log_q.size()), 38'd8);
    dma_command_interface(sdats_pkg::OP_MAN_WR, a);
    move();
    chk(38'(card_u.log_q.size()), 38'd8);
    chk(38'(card_clk_en), 38'h0);
    chk(38'(fmc_err), 38'h0);
    stop_test();
  end
endmodule : test_sd_mmc_auto_transfer_sequencer
